// ===== rcdiv_axil.sv
`timescale 1ns/10ps
`default_nettype none
module rcdiv_axil (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    input wire logic [rcdiv_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [rcdiv_pkg::DATA_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    output logic arready,
    output logic [rcdiv_pkg::DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic [rcdiv_pkg::DATA_W-1:0] rd_data,
    input wire logic rd_ok,
    input wire logic wr_ok,
    output logic wr_stb,
    output logic [rcdiv_pkg::ADDR_W-1:0] wr_addr,
    output logic [rcdiv_pkg::DATA_W-1:0] wr_data,
    output logic [3:0] wr_strb
);
    import rcdiv_pkg::*;

    // Address and data are held until both have arrived, in either order
    assign wr_stb = !awready && !wready && !bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b1;
            wr_addr <= {ADDR_W{1'b0}};
        end else if (clk_en) begin
            if (awvalid && awready) begin
                awready <= 1'b0;
                wr_addr <= awaddr;
            end else if (wr_stb) begin
                awready <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready <= 1'b1;
            wr_data <= {DATA_W{1'b0}};
            wr_strb <= 4'h0;
        end else if (clk_en) begin
            if (wvalid && wready) begin
                wready <= 1'b0;
                wr_data <= wdata;
                wr_strb <= wstrb;
            end else if (wr_stb) begin
                wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else if (clk_en) begin
            if (wr_stb) begin
                bvalid <= 1'b1;
                bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= {DATA_W{1'b0}};
            rresp <= RESP_OKAY;
        end else if (clk_en) begin
            if (arvalid && arready) begin
                arready <= 1'b0;
                rvalid <= 1'b1;
                rdata <= rd_ok ? rd_data : {DATA_W{1'b0}};
                rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (rvalid && rready) begin
                rvalid <= 1'b0;
                arready <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ===== rcdiv_far_end.sv
`timescale 1ns/10ps
`default_nettype none
// Far side: the pin load and the data modulator that consume the divided clock
module rcdiv_far_end (
    input wire logic aclk,
    input wire logic pin_o,
    input wire logic pin_oe_n,
    input wire logic mod_clk,
    output logic pin_wire,
    output int mod_highs,
    output int pin_highs
);
    logic last_drv;
    initial begin
        last_drv = 1'b0;
        mod_highs = 0;
        pin_highs = 0;
    end
    // No pull on the pin: a released line shows the inverse of its last level
    assign pin_wire = pin_oe_n ? ~last_drv : pin_o;
    always @(posedge aclk) begin
        if (pin_oe_n === 1'b0) begin
            last_drv <= pin_o;
        end
        if (mod_clk === 1'b1) begin
            mod_highs <= mod_highs + 1;
        end
        if (pin_wire === 1'b1) begin
            pin_highs <= pin_highs + 1;
        end
    end
endmodule
`default_nettype wire

// ===== rcdiv_gen.sv
`timescale 1ns/10ps
`default_nettype none
module rcdiv_gen #(
    parameter int CNT_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    input wire logic run,
    input wire logic [2:0] div_sel,
    input wire logic [1:0] duty_sel,
    output logic clk_q
);
    import rcdiv_pkg::*;

    generate
        if (CNT_W < CNT_W_MIN) begin : g_bad_width
            $error("rcdiv_gen: CNT_W too small for divide by 128");
        end
    endgenerate

    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] last;
    logic [CNT_W-1:0] next_cnt;

    // Compare with >= so a smaller divider chosen mid-period wraps at once
    always_comb begin
        last = CNT_W'(div_period(div_sel) - 8'h01);
        next_cnt = (cnt >= last) ? {CNT_W{1'b0}} : cnt + 1'b1;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt <= {CNT_W{1'b0}};
            clk_q <= 1'b0;
        end else if (clk_en) begin
            if (!run) begin
                cnt <= {CNT_W{1'b0}};
                clk_q <= 1'b0;
            end else begin
                cnt <= next_cnt;
                clk_q <= next_cnt < CNT_W'(high_count(div_sel, duty_sel));
            end
        end
    end
endmodule
`default_nettype wire

// ===== rcdiv_pkg.sv
`default_nettype none
package rcdiv_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam int CTRL_W = 8;
    localparam int CNT_W_MIN = 8;

    localparam logic [ADDR_W-1:0] CTRL_OFF = 4'h0;
    localparam logic [ADDR_W-1:0] STAT_OFF = 4'h4;

    localparam int EN_BIT = 7;
    localparam int OE_BIT = 6;
    localparam int SLR_BIT = 5;
    localparam int DC_MSB = 4;
    localparam int DC_LSB = 3;
    localparam int DIV_MSB = 2;
    localparam int DIV_LSB = 0;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h30;

    localparam int STAT_OUT_BIT = 0;
    localparam int STAT_PIN_BIT = 1;
    localparam int STAT_FOSC4_BIT = 2;
    localparam int STAT_XTAL_BIT = 3;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam logic [1:0] DUTY_ZERO = 2'h0;
    localparam logic [2:0] DIV_BY_2 = 3'h1;
    localparam logic [1:0] FOSC4_HIGH = 2'h2;

    // Period of the divided clock in system clock cycles
    function automatic logic [7:0] div_period(input logic [2:0] code);
        return 8'h01 << code;
    endfunction

    // Cycles high per period; at the two fastest settings one cycle is the finest step
    function automatic logic [7:0] high_count(input logic [2:0] code, input logic [1:0] duty);
        logic [9:0] prod;
        prod = 10'(div_period(code)) * 10'(duty);
        if (duty == DUTY_ZERO) begin
            return 8'h00;
        end
        if (code <= DIV_BY_2) begin
            return 8'h01;
        end
        return prod[9:2];
    endfunction
endpackage
`default_nettype wire

// ===== rcdiv_top.sv
// Summary of operation
// - Divider counts only on the system clock
// - Module runs only while enable bit set
// - Divided clock drives pin only with pin-enable bit set
// - Divider code selects divide 1 to 128
// - Duty code selects 0, 25, 50, 75 percent
// - Undivided output stays high, zero stays zero
// - Divide-by-two quarter duties only approximate
// - Slew-limit output follows its control bit
// - Reset disables module, restores control defaults
// - Crystal modes keep pin as oscillator input
// - Instruction clock on pin takes priority over divider
// - Modulator clock runs even when pin blocked
// - Divided clock feeds the data modulator
// - Sleep stops module, outputs hold level
//
// The register offsets and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module rcdiv_top #(
    parameter int CNT_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    input wire logic [rcdiv_pkg::ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [rcdiv_pkg::DATA_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [rcdiv_pkg::ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [rcdiv_pkg::DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic crystal_mode_sel,
    input wire logic instr_clock_output_enable_n,
    output logic reference_clock_pin_o,
    output logic reference_clock_pin_oe_n,
    output logic slew_limit_en,
    output logic modulator_clk
);
    import rcdiv_pkg::*;

    logic [CTRL_W-1:0] reference_clock_control;
    logic [1:0] fosc4_cnt;
    logic fosc4;
    logic wr_stb;
    logic wr_ok;
    logic rd_ok;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data;
    logic [3:0] wr_strb;
    logic [DATA_W-1:0] rd_data;
    logic refclk_enable;
    logic refclk_pin_output_enable;
    logic [1:0] duty_select;
    logic [2:0] divider_select;
    logic prot_unused;

    assign refclk_enable = reference_clock_control[EN_BIT];
    assign refclk_pin_output_enable = reference_clock_control[OE_BIT];
    assign duty_select = reference_clock_control[DC_MSB:DC_LSB];
    assign divider_select = reference_clock_control[DIV_MSB:DIV_LSB];
    // Protection attributes carry no meaning for this slave
    assign prot_unused = ^{awprot, arprot};

    rcdiv_axil u_bus (
        .aclk(aclk),
        .aresetn(aresetn),
        .clk_en(clk_en),
        .awaddr(awaddr),
        .awvalid(awvalid),
        .awready(awready),
        .wdata(wdata),
        .wstrb(wstrb),
        .wvalid(wvalid),
        .wready(wready),
        .bresp(bresp),
        .bvalid(bvalid),
        .bready(bready),
        .arvalid(arvalid),
        .arready(arready),
        .rdata(rdata),
        .rresp(rresp),
        .rvalid(rvalid),
        .rready(rready),
        .rd_data(rd_data),
        .rd_ok(rd_ok),
        .wr_ok(wr_ok),
        .wr_stb(wr_stb),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb)
    );

    // Status is read-only, so a write to it answers with an error
    assign wr_ok = (wr_addr == CTRL_OFF);
    assign rd_ok = (araddr == CTRL_OFF) || (araddr == STAT_OFF);

    always_comb begin
        rd_data = {DATA_W{1'b0}};
        if (araddr == CTRL_OFF) begin
            rd_data[CTRL_W-1:0] = reference_clock_control;
        end else if (araddr == STAT_OFF) begin
            rd_data[STAT_OUT_BIT] = modulator_clk;
            rd_data[STAT_PIN_BIT] = !reference_clock_pin_oe_n;
            rd_data[STAT_FOSC4_BIT] = !crystal_mode_sel && !instr_clock_output_enable_n;
            rd_data[STAT_XTAL_BIT] = crystal_mode_sel;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            reference_clock_control <= CTRL_RESET;
        end else if (clk_en && wr_stb && wr_ok && wr_strb[0]) begin
            reference_clock_control <= wr_data[CTRL_W-1:0];
        end
    end

    // Divider keeps running when the pin is claimed elsewhere
    rcdiv_gen #(
        .CNT_W(CNT_W)
    ) u_gen (
        .aclk(aclk),
        .aresetn(aresetn),
        .clk_en(clk_en),
        .run(refclk_enable),
        .div_sel(divider_select),
        .duty_sel(duty_select),
        .clk_q(modulator_clk)
    );

    // Instruction clock is the system clock over four, high for half
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fosc4_cnt <= 2'h0;
        end else if (clk_en) begin
            fosc4_cnt <= fosc4_cnt + 2'h1;
        end
    end
    assign fosc4 = (fosc4_cnt < FOSC4_HIGH);

    // Pin owner in falling priority: crystal, instruction clock, divider
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            reference_clock_pin_o <= 1'b0;
            reference_clock_pin_oe_n <= 1'b1;
        end else if (clk_en) begin
            if (crystal_mode_sel) begin
                reference_clock_pin_o <= 1'b0;
                reference_clock_pin_oe_n <= 1'b1;
            end else if (!instr_clock_output_enable_n) begin
                reference_clock_pin_o <= fosc4;
                reference_clock_pin_oe_n <= 1'b0;
            end else if (refclk_enable && refclk_pin_output_enable) begin
                reference_clock_pin_o <= modulator_clk;
                reference_clock_pin_oe_n <= 1'b0;
            end else begin
                reference_clock_pin_o <= 1'b0;
                reference_clock_pin_oe_n <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            slew_limit_en <= 1'b1;
        end else if (clk_en) begin
            slew_limit_en <= reference_clock_control[SLR_BIT];
        end
    end

    // Helper logic measuring period and high time of the divided clock
    logic mod_d;
    logic steady;
    logic [1:0] rises_seen;
    logic [7:0] gap;
    logic [7:0] hi_len;
    logic [CTRL_W-1:0] ctrl_d;
    logic rise;
    logic fall;

    assign rise = modulator_clk && !mod_d;
    assign fall = !modulator_clk && mod_d;
    // First rise after a change may land mid-period; only the second is a wrap
    assign steady = (rises_seen == 2'h2) && (reference_clock_control == ctrl_d);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mod_d <= 1'b0;
            rises_seen <= 2'h0;
            gap <= 8'h00;
            hi_len <= 8'h00;
            ctrl_d <= CTRL_RESET;
        end else begin
            mod_d <= modulator_clk;
            ctrl_d <= reference_clock_control;
            gap <= rise ? 8'h01 : gap + 8'h01;
            hi_len <= rise ? 8'h01 : hi_len + 8'h01;
            if (!clk_en || reference_clock_control != ctrl_d) begin
                rises_seen <= 2'h0;
            end else if (rise && rises_seen != 2'h2) begin
                rises_seen <= rises_seen + 2'h1;
            end
        end
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_disabled_low: assert property (
        clk_en && !refclk_enable |=> !modulator_clk)
        else $error("divided clock high while module disabled");

    a_pin_oe_off: assert property (
        clk_en && !refclk_pin_output_enable && instr_clock_output_enable_n
        |=> reference_clock_pin_oe_n)
        else $error("pin driven with pin enable cleared");

    a_released_low: assert property (
        reference_clock_pin_oe_n |-> !reference_clock_pin_o)
        else $error("released pin output not low");

    a_crystal_pin_free: assert property (
        clk_en && crystal_mode_sel |=> reference_clock_pin_oe_n)
        else $error("pin driven in crystal mode");

    a_fosc4_priority: assert property (
        clk_en && !crystal_mode_sel && !instr_clock_output_enable_n
        |=> !reference_clock_pin_oe_n && reference_clock_pin_o == $past(fosc4))
        else $error("instruction clock not on pin");

    a_pin_follows_div: assert property (
        clk_en && !crystal_mode_sel && instr_clock_output_enable_n
        && refclk_enable && refclk_pin_output_enable
        |=> reference_clock_pin_o == $past(modulator_clk))
        else $error("pin does not carry divided clock");

    a_slew_bit: assert property (
        clk_en |=> slew_limit_en == $past(reference_clock_control[SLR_BIT]))
        else $error("slew limit does not follow control");

    a_sleep_hold: assert property (
        !clk_en |=> $stable(modulator_clk) && $stable(reference_clock_pin_o)
        && $stable(reference_clock_pin_oe_n))
        else $error("outputs moved while clock enable low");

    a_zero_duty: assert property (
        clk_en && duty_select == DUTY_ZERO |=> !modulator_clk)
        else $error("zero duty gave a high output");

    a_undivided_high: assert property (
        clk_en && refclk_enable && divider_select == 3'h0
        && duty_select != DUTY_ZERO |=> modulator_clk)
        else $error("undivided clock not high");

    a_mod_when_blocked: assert property (
        clk_en && refclk_enable && crystal_mode_sel && duty_select != DUTY_ZERO
        && divider_select == 3'h0 |=> modulator_clk)
        else $error("modulator clock stopped by pin conflict");

    a_period_len: assert property (
        rise && steady && clk_en |-> gap == div_period(divider_select))
        else $error("divided period wrong");

    a_high_len: assert property (
        fall && steady && clk_en |-> hi_len == high_count(divider_select, duty_select))
        else $error("high time wrong for duty");

    // A high sample under unchanged settings means the counter has just wrapped
    a_div2_one_high: assert property (
        clk_en && $past(clk_en) && $stable(reference_clock_control) && refclk_enable
        && divider_select == DIV_BY_2 && duty_select != DUTY_ZERO && modulator_clk
        |=> !modulator_clk)
        else $error("divide by two held high two cycles");

    a_reset_defaults: assert property (@(posedge aclk) disable iff (1'b0)
        !aresetn |=> reference_clock_control == CTRL_RESET && !modulator_clk
        && reference_clock_pin_oe_n)
        else $error("reset did not restore defaults");

    c_div128_period: cover property (
        rise && steady && divider_select == 3'h7);

    c_fosc4_on_pin: cover property (
        !reference_clock_pin_oe_n && !instr_clock_output_enable_n ##4 reference_clock_pin_o);

    c_sleep_high: cover property (
        modulator_clk && !clk_en [*3] ##1 clk_en);

    c_blocked_running: cover property (
        crystal_mode_sel && rise && steady);

    c_div2_running: cover property (
        divider_select == DIV_BY_2 && rise && steady);
endmodule
`default_nettype wire

// ===== reference_clock_divider_tb.sv
`timescale 1ns/10ps
`default_nettype none
module reference_clock_divider_tb;
    import rcdiv_pkg::*;
    logic aclk = 1'b0;
    logic aresetn, clk_en, awvalid, wvalid, bready, arvalid, rready, crystal, instr_n;
    logic [3:0] awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata, d, s;
    logic awready, wready, bvalid, arready, rvalid, pin_o, pin_oe_n, slew, mod_clk, pin_wire;
    logic [1:0] bresp, rresp, r;
    logic [7:0] ctrl;
    logic m0, p0;
    int n_mismatch = 0;
    int num_checks = 0;
    int mod_highs, pin_highs, mh, ph;

    always #25 aclk = ~aclk;

    rcdiv_top rcdiv_top_i (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en), .awaddr(awaddr),
        .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .crystal_mode_sel(crystal),
        .instr_clock_output_enable_n(instr_n), .reference_clock_pin_o(pin_o),
        .reference_clock_pin_oe_n(pin_oe_n), .slew_limit_en(slew), .modulator_clk(mod_clk));
    rcdiv_far_end rcdiv_far_end_i (.aclk(aclk), .pin_o(pin_o), .pin_oe_n(pin_oe_n),
        .mod_clk(mod_clk), .pin_wire(pin_wire), .mod_highs(mod_highs), .pin_highs(pin_highs));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] dt, input logic [3:0] st,
                      output logic [1:0] rs);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= dt;
        wstrb <= st;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready === 1'b1) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready === 1'b1) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end while (!(aw_ok && w_ok));
        do begin
            @(posedge aclk);
        end while (bvalid !== 1'b1);
        rs = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] dt, output logic [1:0] rs);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
        end while (arready !== 1'b1);
        arvalid <= 1'b0;
        do begin
            @(posedge aclk);
        end while (rvalid !== 1'b1);
        dt = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask

    // High cycles counted by the far side over n edges; any whole number of periods works
    task automatic measure(input int n, output int m, output int p);
        int m_start, p_start;
        m_start = mod_highs;
        p_start = pin_highs;
        repeat (n) @(posedge aclk);
        m = mod_highs - m_start;
        p = pin_highs - p_start;
    endtask

    // Reference: high cycles per divided period; the two fastest rates step in whole cycles
    function automatic int exp_high(input int dv, input int dc);
        if (dc == 0) begin
            return 0;
        end
        if (dv <= 1) begin
            return 1;
        end
        return (1 << dv) * dc / 4;
    endfunction

    initial begin
        repeat (60000) @(posedge aclk);
        n_mismatch++;
        tally_and_finish();
    end

    initial begin
        aresetn = 1'b0; clk_en = 1'b1; awaddr = 4'h0; awvalid = 1'b0; wdata = 32'h0;
        wstrb = 4'h0; wvalid = 1'b0; bready = 1'b0; araddr = 4'h0; arvalid = 1'b0;
        rready = 1'b0; crystal = 1'b0; instr_n = 1'b1;
        void'($urandom(45));
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rd(4'h0, d, r);
        check(d, 32'h30);
        check(32'(slew), 32'h1);
        check(32'(mod_clk), 32'h0);
        rd(4'h8, d, r);
        check({d[31:2], r}, {30'h0, RESP_SLVERR});
        wr(4'h4, 32'hFF, 4'hF, r);
        check(32'(r), 32'(RESP_SLVERR));
        for (int dv = 0; dv < 8; dv++) begin
            for (int dc = 0; dc < 4; dc++) begin
                s = $urandom;
                ctrl = 8'hC0 | 8'(dc << 3) | 8'(dv) | (s[0] ? 8'h20 : 8'h00);
                wr(4'h0, {s[31:8], ctrl}, 4'hF, r);
                rd(4'h0, d, r);
                check(d, {24'h0, ctrl});
                check(32'(slew), 32'(ctrl[5]));
                repeat (260) @(posedge aclk);
                measure(2 << dv, mh, ph);
                check(mh, 2 * exp_high(dv, dc));
                check(ph, 2 * exp_high(dv, dc));
                check(32'(pin_oe_n), 32'h0);
            end
        end
        wr(4'h0, 32'h0, 4'hE, r);
        rd(4'h0, d, r);
        check(d, {24'h0, ctrl});
        wr(4'h0, 32'h92, 4'h1, r);
        repeat (8) @(posedge aclk);
        check(32'(pin_oe_n), 32'h1);
        measure(8, mh, ph);
        check(mh, 4);
        wr(4'h0, 32'hD2, 4'h1, r);
        crystal <= 1'b1;
        instr_n <= 1'b0;
        repeat (4) @(posedge aclk);
        check({31'h0, pin_oe_n}, 32'h1);
        check({31'h0, pin_o}, 32'h0);
        measure(8, mh, ph);
        check(mh, 4);
        rd(4'h4, d, r);
        check(d & 32'hC, 32'h8);
        crystal <= 1'b0;
        repeat (4) @(posedge aclk);
        check(32'(pin_oe_n), 32'h0);
        measure(8, mh, ph);
        check(ph, 4);
        check(mh, 4);
        instr_n <= 1'b1;
        @(posedge aclk);
        clk_en <= 1'b0;
        @(posedge aclk);
        m0 = mod_clk;
        p0 = pin_o;
        repeat (20) begin
            @(posedge aclk);
            check({mod_clk, pin_o}, {m0, p0});
        end
        clk_en <= 1'b1;
        wr(4'h0, 32'h52, 4'h1, r);
        repeat (2) @(posedge aclk);
        check(32'(mod_clk), 32'h0);
        check(32'(pin_oe_n), 32'h1);
        measure(16, mh, ph);
        check(mh, 0);
        wr(4'h0, 32'hD2, 4'h1, r);
        repeat (10) @(posedge aclk);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        check({mod_clk, pin_oe_n}, 2'b01);
        rd(4'h0, d, r);
        check(d, 32'h30);
        tally_and_finish();
    end
endmodule
`default_nettype wire
